//--- diag_pkg.sv
/*
  Shared constants for the speaker output diagnostic sequencer.
  Assumes a 20 MHz system clock; all timing derives from it.
*/
package diag_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
  localparam int CYCLE_MS = 100;
  localparam int RECHECK_MS = 1;
  localparam int PULSE_MS = 100;
  localparam int AC_MIN_PEAKS = 3;
  localparam int CH_COUNT = 4;
  // Fault code layout of one channel record
  localparam logic [2:0] FAULT_NONE = 3'h0;
  localparam logic [2:0] FAULT_GND = 3'h1;
  localparam logic [2:0] FAULT_SUPPLY = 3'h2;
  localparam logic [2:0] FAULT_SHORT_LOAD = 3'h3;
  localparam logic [2:0] FAULT_OPEN_LOAD = 3'h4;
  // Load classes from the analog front end
  localparam logic [1:0] LOAD_NORMAL = 2'h0;
  localparam logic [1:0] LOAD_SHORT = 2'h1;
  localparam logic [1:0] LOAD_OPEN = 2'h2;
endpackage

//--- diag_chan_if.sv
/*
  Per-channel carrier between the sequencer top and its channel workers.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/100ps
interface diag_chan_if;
  logic tick;
  logic rearm;
  logic diag_en;
  logic pulse_go;
  logic pulse_end;
  logic prot_trip;
  logic overload;
  logic out_gnd;
  logic out_supply;
  logic [1:0] load_class;
  logic [2:0] fault;
  logic fault_valid;
  logic chan_on;
  logic busy;
  modport top (output tick, rearm, diag_en, pulse_go, pulse_end, prot_trip, overload, out_gnd, out_supply,
    load_class, input fault, fault_valid, chan_on, busy);
  modport chan (input tick, rearm, diag_en, pulse_go, pulse_end, prot_trip, overload, out_gnd, out_supply,
    load_class, output fault, fault_valid, chan_on, busy);
endinterface

//--- diag_channel.sv
/*
  One output channel: turn-on latch, permanent diagnostic and restart.
  Assumes the top supplies a 1 ms tick and synchronised fault inputs.
*/
`timescale 1ns/100ps
module diag_channel (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Carrier to the top
  diag_chan_if.chan link
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RECHECK = 3'b001,
    ST_CYCLE = 3'b010,
    ST_HOLD = 3'b011,
    ST_RESTART = 3'b100
  } chan_state_t;

  typedef struct packed {
    chan_state_t st;
    logic [6:0] ms;
    logic [2:0] fault;
    logic valid;
    logic on;
  } chan_t;

  chan_t cur, next_cur;

  function automatic logic [2:0] classify(input logic gnd, input logic sup, input logic [1:0] ld,
    input logic open_ok);
    if (gnd)
      classify = diag_pkg::FAULT_GND;
    else if (sup)
      classify = diag_pkg::FAULT_SUPPLY;
    else if (ld == diag_pkg::LOAD_SHORT)
      classify = diag_pkg::FAULT_SHORT_LOAD;
    else if (ld == diag_pkg::LOAD_OPEN && open_ok)
      classify = diag_pkg::FAULT_OPEN_LOAD;
    else
      classify = diag_pkg::FAULT_NONE;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_cur = cur;
    // Turn-on result latched at the end of the pulse plateau
    if (link.pulse_end && !cur.valid) begin
      next_cur.fault = classify(link.out_gnd, link.out_supply, link.load_class, 1'b1);
      next_cur.valid = 1'b1;
    end
    if (link.rearm && cur.st != ST_CYCLE) begin
      next_cur.valid = 1'b0;
      next_cur.fault = diag_pkg::FAULT_NONE;
    end
    case (cur.st)
      ST_IDLE: begin
        next_cur.on = !link.pulse_go;
        if (link.prot_trip) begin
          next_cur.on = 1'b0;
          next_cur.ms = 7'h00;
          next_cur.st = link.diag_en ? ST_RECHECK : ST_RESTART;
        end
      end
      ST_RECHECK: begin
        // First tick may come at once; wait one whole ms
        if (link.tick && cur.ms == 7'h00) begin
          next_cur.ms = 7'h01;
        end else if (link.tick) begin
          if (!link.overload) begin
            next_cur.on = 1'b1;
            next_cur.st = ST_IDLE;
          end else if (link.rearm || !cur.valid || cur.fault == diag_pkg::FAULT_NONE) begin
            next_cur.st = ST_CYCLE;
            next_cur.ms = 7'h00;
          end else begin
            next_cur.st = ST_RESTART;
          end
        end
      end
      ST_CYCLE: begin
        if (link.tick) begin
          next_cur.ms = cur.ms + 7'h01;
          if (cur.ms == 7'(diag_pkg::CYCLE_MS - 1)) begin
            // Open load not recognisable while playing
            next_cur.fault = classify(link.out_gnd, link.out_supply, link.load_class, 1'b0);
            next_cur.valid = 1'b1;
            next_cur.st = ST_RESTART;
          end
        end
      end
      ST_RESTART: begin
        if (link.tick) begin
          if (!link.overload) begin
            next_cur.on = 1'b1;
            next_cur.st = ST_IDLE;
          end
        end
      end
      default: next_cur.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      cur <= '{st: ST_IDLE, ms: 7'h00, fault: 3'h0, valid: 1'b0, on: 1'b0};
    else
      cur <= next_cur;
  end

  assign link.fault = cur.fault;
  assign link.fault_valid = cur.valid;
  assign link.chan_on = cur.on;
  assign link.busy = cur.st != ST_IDLE;
endmodule

//--- speaker_output_diagnostics.sv
/*
  Diagnostic sequencer of a four-channel speaker amplifier: turn-on pulse,
  permanent short diagnostics with restart, DC offset and AC tweeter test.
  Assumes analog comparators deliver level flags; a bus read is one pulse
  from the serial interface logic on the same clock.
*/
// Summary of operation
// - Turn-on test at standby exit when requested
// - Turn-on result held until next read
// - Combined step: pulse first, stage stays off
// - Biased amplifier moves to permanent diagnostics
// - Latch status at pulse plateau end, 100 ms
// - Ground/supply criteria gain independent
// - Line-driver load classes at 16 dB option
// - Permanent: grounds, supply, shorted load, offset
// - Restart mode shuts only faulted channels
// - Restart checks every 1 ms
// - Diagnostics enabled: trip starts procedure
// - Recheck after 1 ms, recover if clear
// - Persistent overload runs 100 ms cycle
// - Cycle ends: restart, store, await read
// - Flag offset beyond plus minus 2 V
// - Offset window from read or enable
// - Protection trip abandons offset, AC tests
// - AC test enabled by byte two bit 2
// - Byte two bit 7 selects AC thresholds
// - Tweeter confirmed by three peaks
// - Every read re-arms all diagnostic cycles except a channel's running 100 ms cycle
// - Multiple faults reported over successive reads
`timescale 1ns/100ps
module speaker_output_diagnostics #(
  parameter int CHANNELS = diag_pkg::CH_COUNT,
  parameter int TICK_CYCLES = diag_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Instruction bytes from the serial interface
  input wire logic [7:0] instruction_byte_one,
  input wire logic [7:0] instruction_byte_two,
  input wire logic standby_out,
  input wire logic diag_enable,
  input wire logic gain_low,
  input wire logic line_driver_diag,
  input wire logic bus_read,
  // Analog comparator flags, per channel, asynchronous
  input wire logic [3:0] prot_trip,
  input wire logic [3:0] out_gnd,
  input wire logic [3:0] out_supply,
  input wire logic [3:0] load_short_pa,
  input wire logic [3:0] load_open_pa,
  input wire logic [3:0] load_short_ld,
  input wire logic [3:0] load_open_ld,
  input wire logic [3:0] offset_high,
  input wire logic [3:0] peak_hi_thr,
  input wire logic [3:0] peak_lo_thr,
  // Power stage and results
  output logic stage_standby,
  output logic pulse_active,
  output logic [3:0] chan_enable,
  output logic [11:0] fault_codes,
  output logic [3:0] fault_valid,
  output logic [3:0] offset_flag,
  output logic [3:0] open_tweeter
);
  localparam int NSYNC = 10;

  initial begin
    if (CHANNELS != diag_pkg::CH_COUNT)
      $error("CHANNELS must be four");
    if (TICK_CYCLES < 2 || TICK_CYCLES > 65535)
      $error("TICK_CYCLES out of range");
  end

  typedef struct packed {
    logic [15:0] div;
    logic tick;
    logic standby_q;
    logic pulse;
    logic pulse_done;
    logic [6:0] pulse_ms;
    logic [3:0] off_run;
    logic [3:0] off_flag;
    logic ac_en_q;
    logic [3:0] ac_run;
    logic [3:0][1:0] peak_cnt;
    logic [3:0] peak_q;
    logic [3:0] tweeter_open;
    logic [3:0] rd_offset;
    logic [3:0] rd_tweet;
    logic [11:0] rd_fault;
    logic [3:0] rd_valid;
    logic [3:0] ch_on;
    logic stage_sb;
  } top_t;

  top_t cur, next_cur;
  logic [NSYNC*4-1:0] s1, s2, s3;
  logic [NSYNC*4-1:0] raw, stable, held;
  logic [3:0] c_trip, c_gnd, c_sup, c_off, c_peak;
  logic [1:0] c_load [3:0];
  logic [3:0] ch_fv, ch_on, ch_busy;
  logic [2:0] ch_fault [3:0];
  logic [1:0] next_peak [3:0];

  diag_chan_if chl [3:0] ();

  //////////////////////////////////////////////////////////////////////////////
  // Three-stage synchronisers; value moves when stages two and three agree
  assign raw = {peak_lo_thr, peak_hi_thr, offset_high, load_open_ld, load_short_ld, load_open_pa,
    load_short_pa, out_supply, out_gnd, prot_trip};
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      held <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      held <= stable;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC*4; gi++) begin : g_sync
      assign stable[gi] = (s2[gi] == s3[gi]) ? s3[gi] : held[gi];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Channel workers and analog class selection
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ch
      assign c_trip[gi] = stable[gi];
      assign c_gnd[gi] = stable[4 + gi];
      assign c_sup[gi] = stable[8 + gi];
      assign c_off[gi] = stable[28 + gi];
      assign c_peak[gi] = instruction_byte_two[7] ? stable[36 + gi] : stable[32 + gi];
      // Ground/supply flags pass unchanged at any gain; load class by gain
      assign c_load[gi] = (gain_low && line_driver_diag) ?
        (stable[20 + gi] ? diag_pkg::LOAD_SHORT : stable[24 + gi] ? diag_pkg::LOAD_OPEN : diag_pkg::LOAD_NORMAL) :
        (stable[12 + gi] ? diag_pkg::LOAD_SHORT : stable[16 + gi] ? diag_pkg::LOAD_OPEN : diag_pkg::LOAD_NORMAL);
      assign chl[gi].tick = cur.tick;
      assign chl[gi].rearm = bus_read;
      assign chl[gi].diag_en = diag_enable;
      assign chl[gi].pulse_go = cur.pulse;
      assign chl[gi].pulse_end = cur.pulse_done;
      assign chl[gi].prot_trip = c_trip[gi];
      assign chl[gi].overload = c_trip[gi];
      assign chl[gi].out_gnd = c_gnd[gi];
      assign chl[gi].out_supply = c_sup[gi];
      assign chl[gi].load_class = c_load[gi];
      assign ch_fault[gi] = chl[gi].fault;
      assign ch_fv[gi] = chl[gi].fault_valid;
      assign ch_on[gi] = chl[gi].chan_on;
      assign ch_busy[gi] = chl[gi].busy;
      diag_channel u_ch (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .link(chl[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_cur = cur;
    for (int i = 0; i < 4; i++)
      next_peak[i] = cur.peak_cnt[i];
    next_cur.tick = 1'b0;
    next_cur.pulse_done = 1'b0;
    // Shared millisecond time base
    if (cur.div == 16'(TICK_CYCLES - 1)) begin
      next_cur.div = 16'h0000;
      next_cur.tick = 1'b1;
    end else begin
      next_cur.div = cur.div + 16'h0001;
    end
    // Turn-on pulse on standby exit with diagnostics requested
    next_cur.standby_q = standby_out;
    if (standby_out && !cur.standby_q && diag_enable && !cur.pulse) begin
      next_cur.pulse = 1'b1;
      next_cur.pulse_ms = 7'h00;
    end
    if (cur.pulse && cur.tick) begin
      next_cur.pulse_ms = cur.pulse_ms + 7'h01;
      if (cur.pulse_ms == 7'(diag_pkg::PULSE_MS - 1)) begin
        next_cur.pulse = 1'b0;
        next_cur.pulse_done = 1'b1;
      end
    end
    // Stage biased only once the pulse is over
    next_cur.stage_sb = !standby_out || cur.pulse || next_cur.pulse;
    next_cur.ch_on = ch_on & {4{!next_cur.stage_sb}};
    // Offset window: persistence since last read or enable edge
    for (int i = 0; i < 4; i++) begin
      if (!c_off[i] || c_trip[i])
        next_cur.off_run[i] = 1'b0;
    end
    // Window closes as soon as the enable bit drops
    if (!instruction_byte_one[5])
      next_cur.off_run = 4'h0;
    // AC peak counting, saturating at the required count
    next_cur.ac_en_q = instruction_byte_two[2];
    next_cur.peak_q = c_peak;
    for (int i = 0; i < 4; i++) begin
      if (cur.ac_run[i] && c_peak[i] && !cur.peak_q[i] && cur.peak_cnt[i] != 2'(diag_pkg::AC_MIN_PEAKS))
        next_peak[i] = cur.peak_cnt[i] + 2'h1;
      if (c_trip[i])
        next_cur.ac_run[i] = 1'b0;
    end
    if (instruction_byte_two[2] && !cur.ac_en_q) begin
      next_cur.ac_run = 4'hF;
      for (int i = 0; i < 4; i++)
        next_peak[i] = 2'h0;
    end
    if (instruction_byte_one[5] && !cur.off_run[0] && !cur.off_run[1] && !cur.off_run[2] && !cur.off_run[3]
      && cur.off_flag == 4'h0)
      next_cur.off_run = instruction_byte_one[5] ? ~c_trip : 4'h0;
    // Read: publish previous cycle, then re-arm all but a running 100 ms cycle
    if (bus_read) begin
      for (int i = 0; i < 4; i++) begin
        next_cur.rd_fault[i*3 +: 3] = ch_fault[i];
        next_cur.tweeter_open[i] = instruction_byte_two[2] &&
          !(cur.ac_run[i] && cur.peak_cnt[i] == 2'(diag_pkg::AC_MIN_PEAKS));
        next_peak[i] = 2'h0;
      end
      next_cur.rd_valid = ch_fv;
      next_cur.rd_offset = cur.off_run & c_off & {4{instruction_byte_one[5]}};
      next_cur.off_flag = cur.off_run & c_off & {4{instruction_byte_one[5]}};
      next_cur.off_run = instruction_byte_one[5] ? ~c_trip : 4'h0;
      next_cur.ac_run = instruction_byte_two[2] ? ~c_trip : 4'h0;
    end
    for (int i = 0; i < 4; i++)
      next_cur.peak_cnt[i] = next_peak[i];
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cur <= '0;
      cur.stage_sb <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign stage_standby = cur.stage_sb;
  assign pulse_active = cur.pulse;
  assign chan_enable = cur.ch_on;
  assign fault_codes = cur.rd_fault;
  assign fault_valid = cur.rd_valid;
  assign offset_flag = cur.rd_offset;
  assign open_tweeter = cur.tweeter_open;
endmodule

//--- sod_chk_sva.sv
/* Port checker for the speaker diagnostic sequencer.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
module sod_chk #(
  parameter int TICK_CYCLES = 20
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Controls
  input wire logic [7:0] instruction_byte_one,
  input wire logic [7:0] instruction_byte_two,
  input wire logic standby_out,
  input wire logic diag_enable,
  input wire logic bus_read,
  // Results
  input wire logic stage_standby,
  input wire logic pulse_active,
  input wire logic [3:0] chan_enable,
  input wire logic [11:0] fault_codes,
  input wire logic [3:0] fault_valid,
  input wire logic [3:0] offset_flag,
  input wire logic [3:0] open_tweeter
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // First tick may be partial
  localparam int PLO = (diag_pkg::PULSE_MS - 1) * TICK_CYCLES;
  localparam int PHI = (diag_pkg::PULSE_MS + 1) * TICK_CYCLES;
  int pl_cnt;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !pulse_active) begin
      pl_cnt <= 0;
    end else begin
      pl_cnt <= pl_cnt + 1;
    end
  end
  ////////////////////////////////////////
  property p_reset_vals;
    disable iff (1'b0) sys_rst |=> stage_standby && !pulse_active && chan_enable == 4'h0 && fault_valid == 4'h0;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("outputs off their reset values");
  property p_codes_hold;
    !bus_read |=> $stable(fault_codes) && $stable(fault_valid);
  endproperty
  a_codes_hold: assert property (p_codes_hold) else $error("fault record moved without a read");
  property p_offset_hold;
    not (!bus_read ##1 $changed(offset_flag));
  endproperty
  a_offset_hold: assert property (p_offset_hold) else $error("offset flag moved without a read");
  property p_tweeter_hold;
    !bus_read |=> $stable(open_tweeter);
  endproperty
  a_tweeter_hold: assert property (p_tweeter_hold) else $error("tweeter flag moved without a read");
  property p_pulse_start;
    $rose(standby_out) && diag_enable && stage_standby && !pulse_active |=> pulse_active;
  endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("turn-on pulse did not start");
  property p_pulse_len;
    $fell(pulse_active) |-> pl_cnt >= PLO && pl_cnt <= PHI;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("turn-on pulse length wrong");
  property p_pulse_stage;
    pulse_active |-> stage_standby && chan_enable == 4'h0;
  endproperty
  a_pulse_stage: assert property (p_pulse_stage) else $error("stage active during pulse");
  property p_ofs_off;
    bus_read && !instruction_byte_one[5] ##1 1'b1 |-> offset_flag == 4'h0;
  endproperty
  a_ofs_off: assert property (p_ofs_off) else $error("offset flag with test disabled");
  property p_ac_off;
    bus_read && !instruction_byte_two[2] |=> open_tweeter == 4'h0;
  endproperty
  a_ac_off: assert property (p_ac_off) else $error("tweeter flag with test disabled");
  c_pulse_done: cover property ($fell(pulse_active));
  c_offset_seen: cover property ($rose(|offset_flag));
  c_tweeter_open: cover property ($rose(|open_tweeter));
endmodule
bind speaker_output_diagnostics sod_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .instruction_byte_one(instruction_byte_one), .instruction_byte_two(instruction_byte_two),
  .standby_out(standby_out), .diag_enable(diag_enable), .bus_read(bus_read), .stage_standby(stage_standby),
  .pulse_active(pulse_active), .chan_enable(chan_enable), .fault_codes(fault_codes),
  .fault_valid(fault_valid), .offset_flag(offset_flag), .open_tweeter(open_tweeter));

//--- host_model.sv
/* Host model: result reads and test tone peaks.
   Assumes tasks are called between clock edges. */
`timescale 1ns/100ps
module host_model (
  // Clock
  input wire logic sys_clk,
  // To the block
  output logic bus_read,
  output logic [3:0] peak_hi_thr,
  output logic [3:0] peak_lo_thr
);
  initial begin
    bus_read = 1'b0;
    peak_hi_thr = 4'h0;
    peak_lo_thr = 4'h0;
  end
  // Polls far faster than a real host, to keep runs short
  task automatic read();
    @(negedge sys_clk);
    bus_read = 1'b1;
    @(negedge sys_clk);
    bus_read = 1'b0;
  endtask
  // Three tone cycles; peaks wide for the input filter
  task automatic tone(input int n_hi, input int n_lo);
    for (int i = 0; i < 3; i++) begin
      @(negedge sys_clk);
      peak_hi_thr = (i < n_hi) ? 4'hF : 4'h0;
      peak_lo_thr = (i < n_lo) ? 4'hF : 4'h0;
      repeat (4) @(negedge sys_clk);
      peak_hi_thr = 4'h0;
      peak_lo_thr = 4'h0;
      repeat (4) @(negedge sys_clk);
    end
  endtask
endmodule

//--- testbench.sv
/* Self-checking bench for the speaker diagnostic sequencer.
   Assumes host_model and the checker are compiled first. */
`timescale 1ns/100ps
module testbench;
  localparam int T = 20;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] instruction_byte_one = 8'h00;
  logic [7:0] instruction_byte_two = 8'h00;
  logic standby_out = 1'b0;
  logic diag_enable = 1'b0;
  logic gain_low = 1'b0;
  logic line_driver_diag = 1'b0;
  logic [3:0] prot_trip = 4'h0;
  logic [3:0] out_gnd = 4'h0;
  logic [3:0] out_supply = 4'h0;
  logic [3:0] load_open_pa = 4'h0;
  logic [3:0] load_open_ld = 4'h0;
  logic [3:0] offset_high = 4'h0;
  logic bus_read, stage_standby, pulse_active;
  logic [3:0] peak_hi_thr, peak_lo_thr, chan_enable, fault_valid, offset_flag, open_tweeter;
  logic [11:0] fault_codes;
  int err_total = 0;
  int checks_done = 0;
  always #25 sys_clk = ~sys_clk;
  host_model host_u (.sys_clk(sys_clk), .bus_read(bus_read), .peak_hi_thr(peak_hi_thr), .peak_lo_thr(peak_lo_thr));
  speaker_output_diagnostics #(.TICK_CYCLES(T)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .instruction_byte_one(instruction_byte_one), .instruction_byte_two(instruction_byte_two),
    .standby_out(standby_out), .diag_enable(diag_enable), .gain_low(gain_low),
    .line_driver_diag(line_driver_diag), .bus_read(bus_read), .prot_trip(prot_trip), .out_gnd(out_gnd),
    .out_supply(out_supply), .load_short_pa(4'h0), .load_open_pa(load_open_pa), .load_short_ld(4'h0),
    .load_open_ld(load_open_ld), .offset_high(offset_high), .peak_hi_thr(peak_hi_thr),
    .peak_lo_thr(peak_lo_thr), .stage_standby(stage_standby), .pulse_active(pulse_active),
    .chan_enable(chan_enable), .fault_codes(fault_codes), .fault_valid(fault_valid),
    .offset_flag(offset_flag), .open_tweeter(open_tweeter));
  ////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Results land one cycle after the read pulse
  task automatic rd();
    host_u.read();
    cyc(2);
  endtask
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (err_total == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wait_pulse();
    int n;
    n = 0;
    while (pulse_active !== 1'b0 && n < 3000) begin
      cyc(1);
      n++;
    end
    if (n == 3000) begin
      err_total++;
      print_verdict();
    end
  endtask
  ////////////////////////////////////////
  initial begin
    cyc(2);
    sys_rst = 1'b0;
    // Open load at 26 dB, then in line-driver mode
    for (int g = 0; g < 2; g++) begin
      gain_low = g[0];
      line_driver_diag = g[0];
      load_open_pa = g ? 4'h1 : 4'h2;
      load_open_ld = 4'h2;
      out_gnd = 4'h4;
      out_supply = 4'h8;
      cyc(20);
      standby_out = 1'b1;
      diag_enable = 1'b1;
      cyc(2);
      chk("pulse_active", 12'h001, {11'h0, pulse_active});
      chk("stage_standby", 12'h001, {11'h0, stage_standby});
      wait_pulse();
      {load_open_pa, load_open_ld, out_gnd, out_supply} = 16'h0000;
      cyc(10);
      chk("chan_enable", 12'h00F, {8'h0, chan_enable});
      rd();
      chk("turn_on_codes", {diag_pkg::FAULT_SUPPLY, diag_pkg::FAULT_GND, diag_pkg::FAULT_OPEN_LOAD,
        diag_pkg::FAULT_NONE}, fault_codes);
      chk("fault_valid", 12'h00F, {8'h0, fault_valid});
      rd();
      chk("fault_codes", 12'h000, fault_codes);
      chk("fault_valid", 12'h000, {8'h0, fault_valid});
      if (g == 0) begin
        standby_out = 1'b0;
      end
    end
    // Brief trip, then a lasting short to ground
    prot_trip = 4'h1;
    cyc(8);
    prot_trip = 4'h0;
    cyc(3 * T);
    chk("chan_enable", 12'h00F, {8'h0, chan_enable});
    prot_trip = 4'h2;
    out_gnd = 4'h2;
    cyc(5 * T);
    chk("chan_enable", 12'h00D, {8'h0, chan_enable});
    cyc(110 * T);
    rd();
    chk("perm_codes", {6'h00, diag_pkg::FAULT_GND, 3'h0}, fault_codes);
    prot_trip = 4'h0;
    out_gnd = 4'h0;
    cyc(3 * T);
    chk("chan_enable", 12'h00F, {8'h0, chan_enable});
    rd();
    rd();
    chk("fault_codes", 12'h000, fault_codes);
    // Offset test with no tone playing
    offset_high = 4'h5;
    cyc(10);
    instruction_byte_one = 8'h20;
    cyc(40);
    rd();
    chk("offset_flag", 12'h005, {8'h0, offset_flag});
    prot_trip = 4'h4;
    cyc(8);
    prot_trip = 4'h0;
    cyc(3 * T);
    rd();
    chk("offset_flag_2", 12'h000, {11'h0, offset_flag[2]});
    offset_high = 4'h0;
    cyc(20);
    rd();
    chk("offset_flag", 12'h000, {8'h0, offset_flag});
    instruction_byte_one = 8'h00;
    // Both threshold selections: three peaks pass, fewer fail
    for (int t = 0; t < 2; t++) begin
      instruction_byte_two = t ? 8'h84 : 8'h04;
      cyc(5);
      rd();
      host_u.tone(t ? 0 : 3, 3);
      rd();
      chk("open_tweeter", 12'h000, {8'h0, open_tweeter});
      host_u.tone(0, t ? 2 : 3);
      rd();
      chk("open_tweeter", 12'h00F, {8'h0, open_tweeter});
    end
    instruction_byte_two = 8'h00;
    rd();
    chk("open_tweeter", 12'h000, {8'h0, open_tweeter});
    print_verdict();
  end
endmodule
